// [rtl/calid_regs.sv]
// Summary of operation
// - Hysteresis register read/write at pointer 21h, resets to 0Ah.
// - Hysteresis bits D7..D0 line up with temperature bits 15..8, one degree per count.
// - Offset register uses the remote result's encoding and bit alignment.
// - Each finished remote conversion gets the offset added before it is presented.
// - Reading pointer FEh returns the fixed maker code.
// - Model identification returns a fixed code chosen per built variant.
// - Both identification registers are read-only; writes never change them.
// - Alarm releases only after temperature falls hysteresis below limit; host keeps it below.
`timescale 1ns/10ps
`default_nettype none

module calid_regs
    import calid_pkg::*;
#(
    // Arbitrary neutral codes, not those of any real part
    parameter logic [7:0] MAKER_ID_CODE = 8'hA5,
    parameter logic [7:0] MODEL_ID_CODE = 8'h3C
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register port from the serial bus logic
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_ptr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_ack,
    // Conversion engine
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_raw,
    output logic      [15:0] remote_temp,
    output logic             remote_valid,
    // Over-temperature alarm
    input  wire logic [7:0]  overtemp_limit,
    output logic             overtemp_pin
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed
    {
        logic [7:0]  hyst;
        logic [7:0]  ofs;
        logic [7:0]  rdata;
        logic        ack;
        logic [15:0] temp;
        logic        valid;
        logic        alarm;
    } calid_st_t;

    calid_st_t          st_r;
    calid_st_t          st_nxt;
    logic [CMP_W-1:0]   temp_deg;
    logic [CMP_W-1:0]   limit_deg;
    logic [CMP_W-1:0]   release_deg;
    logic [7:0]         rd_mux;

    calid_ofs_if        ofs_ch ();

    // ========================================================================
    // Offset correction
    // ========================================================================
    assign ofs_ch.start  = conv_done;
    assign ofs_ch.raw    = conv_raw;
    assign ofs_ch.offset = st_r.ofs;

    calid_ofs_add u_ofs_add
    (
        .clk   (clk),
        .rst_n (rst_n),
        .ofs   (ofs_ch.add)
    );

    // ========================================================================
    // Read mux
    // ========================================================================
    always_comb
    begin
        case (reg_ptr)
            PTR_HYST:
            begin
                rd_mux = st_r.hyst;
            end
            PTR_REM_OFS:
            begin
                rd_mux = st_r.ofs;
            end
            PTR_MAKER_ID:
            begin
                rd_mux = MAKER_ID_CODE;
            end
            PTR_MODEL_ID:
            begin
                rd_mux = MODEL_ID_CODE;
            end
            default:
            begin
                rd_mux = DATA_ZERO;
            end
        endcase
    end

    // ========================================================================
    // Alarm comparison in whole degrees, signed with headroom
    // ========================================================================
    always_comb
    begin
        temp_deg    = {{(CMP_W-BYTE_W){ofs_ch.result[TEMP_W-1]}},
                       ofs_ch.result[TEMP_W-1:TEMP_W-BYTE_W]};
        limit_deg   = {{(CMP_W-BYTE_W){overtemp_limit[BYTE_W-1]}}, overtemp_limit};
        // Hysteresis counts whole degrees, so it lines up with the high byte
        release_deg = limit_deg - {{(CMP_W-BYTE_W){1'b0}}, st_r.hyst};
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.ack   = 1'b0;
        st_nxt.valid = 1'b0;

        if (reg_rd)
        begin
            st_nxt.rdata = rd_mux;
            st_nxt.ack   = 1'b1;
        end

        if (reg_wr)
        begin
            st_nxt.ack = 1'b1;
            case (reg_ptr)
                PTR_HYST:
                begin
                    st_nxt.hyst = reg_wdata;
                end
                PTR_REM_OFS:
                begin
                    st_nxt.ofs = reg_wdata;
                end
                // Identification codes are constants, nothing to store
                PTR_MAKER_ID, PTR_MODEL_ID:
                begin
                    st_nxt.ofs = st_r.ofs;
                end
                default:
                begin
                    st_nxt.hyst = st_r.hyst;
                end
            endcase
        end

        if (ofs_ch.done)
        begin
            st_nxt.temp  = ofs_ch.result;
            st_nxt.valid = 1'b1;
            // A hysteresis at or above the limit can hold the alarm forever
            if ($signed(temp_deg) >= $signed(limit_deg))
            begin
                st_nxt.alarm = 1'b1;
            end
            else if ($signed(temp_deg) <= $signed(release_deg))
            begin
                st_nxt.alarm = 1'b0;
            end
        end
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r <= '{hyst:  HYST_RESET,
                      ofs:   OFS_RESET,
                      rdata: DATA_ZERO,
                      ack:   1'b0,
                      temp:  TEMP_ZERO,
                      valid: 1'b0,
                      alarm: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign reg_rdata    = st_r.rdata;
    assign reg_ack      = st_r.ack;
    assign remote_temp  = st_r.temp;
    assign remote_valid = st_r.valid;
    assign overtemp_pin = st_r.alarm;

endmodule

`default_nettype wire

// [rtl/calid_pkg.sv]
package calid_pkg;

    // ========================================================================
    // Pointer map
    // ========================================================================
    localparam logic [7:0]  PTR_REM_OFS       = 8'h11;
    localparam logic [7:0]  PTR_HYST          = 8'h21;
    localparam logic [7:0]  PTR_MAKER_ID      = 8'hFE;
    localparam logic [7:0]  PTR_MODEL_ID      = 8'hFF;

    // ========================================================================
    // Reset values and fixed data
    // ========================================================================
    localparam logic [7:0]  HYST_RESET        = 8'h0A;
    localparam logic [7:0]  OFS_RESET         = 8'h00;
    localparam logic [7:0]  DATA_ZERO         = 8'h00;
    localparam logic [7:0]  LIMIT_RESET       = 8'h00;

    // ========================================================================
    // Temperature word layout
    // ========================================================================
    localparam int          TEMP_W            = 16;
    localparam int          BYTE_W            = 8;
    localparam int          CMP_W             = 10;
    localparam logic [15:0] TEMP_ZERO         = 16'h0000;
    localparam logic [15:0] TEMP_POS_MAX      = 16'h7FF0;
    localparam logic [15:0] TEMP_NEG_MIN      = 16'h8000;
    localparam logic [15:0] TEMP_FRAC_MASK    = 16'hFFF0;
    localparam logic [7:0]  OFS_FRAC_ZERO     = 8'h00;

endpackage

// [rtl/calid_ofs_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface calid_ofs_if;

    // ========================================================================
    // Offset correction request and answer
    // ========================================================================
    logic        start;
    logic [15:0] raw;
    logic [7:0]  offset;
    logic        done;
    logic [15:0] result;

    modport ctrl
    (
        output start,
        output raw,
        output offset,
        input  done,
        input  result
    );

    modport add
    (
        input  start,
        input  raw,
        input  offset,
        output done,
        output result
    );

endinterface

`default_nettype wire

// [rtl/calid_ofs_add.sv]
`timescale 1ns/10ps
`default_nettype none

module calid_ofs_add
    import calid_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // Correction channel
    calid_ofs_if.add    ofs
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed
    {
        logic        done;
        logic [15:0] result;
    } calid_add_st_t;

    calid_add_st_t st_r;
    calid_add_st_t st_nxt;
    logic [16:0]   sum;

    // ========================================================================
    // Offset sits on the whole-degree byte, same as the result
    // ========================================================================
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        // One guard bit on each operand keeps the sum at exactly 17 bits
        sum         = {ofs.raw[TEMP_W-1], ofs.raw}
                    + {ofs.offset[BYTE_W-1], ofs.offset, OFS_FRAC_ZERO};
        if (ofs.start)
        begin
            st_nxt.done = 1'b1;
            // Clamp rather than wrap, a wrapped reading would flip the alarm
            if (sum[TEMP_W] != sum[TEMP_W-1])
            begin
                st_nxt.result = sum[TEMP_W] ? TEMP_NEG_MIN : TEMP_POS_MAX;
            end
            else
            begin
                st_nxt.result = sum[TEMP_W-1:0] & TEMP_FRAC_MASK;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r <= '{done: 1'b0, result: TEMP_ZERO};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign ofs.done   = st_r.done;
    assign ofs.result = st_r.result;

endmodule

`default_nettype wire

// [rtl/calid_regs_unused_placeholder_none.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [verification/calid_regs_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module calid_regs_asserts
    import calid_pkg::*;
#(
    parameter logic [7:0] MAKER_ID_CODE = 8'hA5,
    parameter logic [7:0] MODEL_ID_CODE = 8'h3C
)
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_ptr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_ack,
    // Conversion and alarm
    input wire logic        conv_done,
    input wire logic [15:0] remote_temp,
    input wire logic        remote_valid,
    input wire logic        overtemp_pin
);
    // ==================
    // Checks
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_ack_follow: assert property ((reg_rd || reg_wr) |=> reg_ack)
        else $error("strobe without ack");
    chk_ack_cause: assert property (reg_ack |-> $past(reg_rd || reg_wr))
        else $error("ack without strobe");
    chk_maker_code: assert property (
        reg_rd && reg_ptr == PTR_MAKER_ID |=> reg_rdata == MAKER_ID_CODE)
        else $error("maker code wrong");
    chk_model_code: assert property (
        reg_rd && reg_ptr == PTR_MODEL_ID |=> reg_rdata == MODEL_ID_CODE)
        else $error("model code wrong");
    // Write, one idle cycle, then read back; bytes never come back to back here
    chk_hyst_back: assert property (
        reg_wr && !reg_rd && reg_ptr == PTR_HYST ##1 !reg_wr ##1
        reg_rd && !reg_wr && reg_ptr == PTR_HYST |=> reg_rdata == $past(reg_wdata, 3))
        else $error("hysteresis readback wrong");
    chk_valid_delay: assert property (conv_done |-> ##2 remote_valid)
        else $error("result late");
    chk_frac_zero: assert property (remote_valid |-> remote_temp[3:0] == 4'h0)
        else $error("fraction nibble set");
    chk_alarm_moment: assert property ($changed(overtemp_pin) |-> remote_valid)
        else $error("alarm moved off conversion");

    cover property (conv_done ##2 remote_valid);
    cover property ($rose(overtemp_pin));
    cover property (reg_wr && reg_ptr == PTR_MAKER_ID ##1 reg_ack);
endmodule
`default_nettype wire

// [verification/calid_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module calid_host_model
(
    // Clock
    input  wire logic       clk,
    // Register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_ptr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_ack
);
    // ==================
    // Byte transfer
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_ptr   = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic xfer(input logic w, input logic [7:0] p, d, output logic [7:0] q, output logic ak);
        @(negedge clk);
        reg_wr    = w;
        reg_rd    = !w;
        reg_ptr   = p;
        reg_wdata = d;
        @(negedge clk);
        ak        = reg_ack;
        q         = reg_rdata;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        // Idle lines flip so a stale value cannot pass for an answer
        reg_ptr   = ~p;
        reg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import calid_pkg::*;
;
    // Arbitrary codes, not those of any real part
    localparam logic [7:0] MAKER = 8'h6B;
    localparam logic [7:0] MODEL = 8'h2D;
    logic        clk, rst_n, reg_wr, reg_rd, reg_ack, conv_done, remote_valid, overtemp_pin;
    logic [7:0]  reg_ptr, reg_wdata, reg_rdata, overtemp_limit, hyst_m, ofs_m;
    logic [15:0] conv_raw, remote_temp;
    logic        alarm_m;
    int          errors, total_checks;
    logic [7:0]  ptrs [5] = '{PTR_HYST, PTR_REM_OFS, PTR_MAKER_ID, PTR_MODEL_ID, 8'h42};

    calid_regs #(.MAKER_ID_CODE(MAKER), .MODEL_ID_CODE(MODEL)) dut
    (.clk, .rst_n, .reg_wr, .reg_rd, .reg_ptr, .reg_wdata, .reg_rdata, .reg_ack, .conv_done,
     .conv_raw, .remote_temp, .remote_valid, .overtemp_limit, .overtemp_pin);
    calid_host_model host (.clk, .reg_wr, .reg_rd, .reg_ptr, .reg_wdata, .reg_rdata, .reg_ack);

    // ==================
    // Helpers
    task automatic chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] reg_exp(input logic [7:0] p);
        case (p)
            PTR_HYST:     return hyst_m;
            PTR_REM_OFS:  return ofs_m;
            PTR_MAKER_ID: return MAKER;
            PTR_MODEL_ID: return MODEL;
            default:      return DATA_ZERO;
        endcase
    endfunction
    function automatic logic [15:0] exp_temp(input logic [15:0] raw, input logic [7:0] ofs);
        int s;
        s = $signed(raw) + $signed({ofs, 8'h00});
        if (s > 32752) return TEMP_POS_MAX;
        if (s < -32768) return TEMP_NEG_MIN;
        return 16'(s) & TEMP_FRAC_MASK;
    endfunction
    task automatic acc(input logic w, input logic [7:0] p, d);
        logic [7:0] q;
        logic       ak;
        host.xfer(w, p, d, q, ak);
        chk({15'h0, ak}, 16'h0001);
        if (w && p == PTR_HYST) hyst_m = d;
        if (w && p == PTR_REM_OFS) ofs_m = d;
        if (!w) chk({8'h00, q}, {8'h00, reg_exp(p)});
    endtask
    task automatic conv(input logic [15:0] raw);
        logic [15:0] e;
        int          hi;
        e  = exp_temp(raw, ofs_m);
        hi = $signed(e[15:8]);
        if (hi >= $signed(overtemp_limit)) alarm_m = 1'b1;
        else if (hi <= $signed(overtemp_limit) - int'(hyst_m)) alarm_m = 1'b0;
        @(negedge clk);
        conv_done = 1'b1;
        conv_raw  = raw;
        @(negedge clk);
        conv_done = 1'b0;
        conv_raw  = ~raw;
        for (int i = 0; i < 4 && remote_valid !== 1'b1; i++) @(negedge clk);
        chk({15'h0, remote_valid}, 16'h0001);
        chk(remote_temp, e);
        chk({15'h0, overtemp_pin}, {15'h0, alarm_m});
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==================
    // Clock, watchdog, tests
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #200_000;
        errors++;
        end_of_test();
    end
    initial
    begin
        rst_n = 1'b0;
        conv_done = 1'b0;
        conv_raw = TEMP_ZERO;
        overtemp_limit = 8'h28;
        errors = 0;
        total_checks = 0;
        hyst_m = HYST_RESET;
        ofs_m = OFS_RESET;
        alarm_m = 1'b0;
        void'($urandom(55066));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        foreach (ptrs[i]) acc(1'b0, ptrs[i], 8'h00);
        acc(1'b1, PTR_MAKER_ID, 8'($urandom));
        acc(1'b1, PTR_MODEL_ID, 8'($urandom));
        foreach (ptrs[i]) acc(1'b0, ptrs[i], 8'h00);
        // Hysteresis kept below the limit, as the host must
        acc(1'b1, PTR_HYST, 8'h05);
        acc(1'b0, PTR_HYST, 8'h00);
        conv(16'h2800);
        conv(16'h2400);
        conv(16'h2300);
        acc(1'b1, PTR_REM_OFS, 8'h7F);
        conv(16'h7F00);
        acc(1'b1, PTR_REM_OFS, 8'h80);
        conv(16'h8000);
        repeat (40)
        begin
            acc(1'b1, PTR_HYST, 8'($urandom_range(0, 39)));
            acc(1'b1, PTR_REM_OFS, 8'($urandom_range(0, 32) - 16));
            acc(1'b0, ptrs[$urandom_range(0, 4)], 8'h00);
            conv(16'($urandom_range(0, 16'h4FFF)));
        end
        end_of_test();
    end
endmodule

bind calid_regs calid_regs_asserts
    #(.MAKER_ID_CODE(MAKER_ID_CODE), .MODEL_ID_CODE(MODEL_ID_CODE)) u_chk
    (.clk, .rst_n, .reg_wr, .reg_rd, .reg_ptr, .reg_wdata, .reg_rdata, .reg_ack,
     .conv_done, .remote_temp, .remote_valid, .overtemp_pin);
`default_nettype wire
